// >>> design/wpc_defs.svh
// constants for the wake pin and transceiver configuration registers
// Summary of operation
// [R1] host writes addr 000010 frame; reads with zeros
// [R2] register A packs pins 0,2,3,4 selections
// [R3] codes 00 none, 01 rising, 11 any
// [R4] code 10 wakes on falling or low
// [R5] fields reset only by power-on reset
// [R6] response: global flags high, content low byte
// [R7] register B: pin5, CAN, LIN fields, bit3 reserved
// [R8] CAN wake timeout 120 us or 2.8 ms
// [R9] LIN slew 20k, 10k, or fast
// [R10] low-supply bit gates LIN recessive forcing
`ifndef WPC_DEFS_SVH
`define WPC_DEFS_SVH
`define WPC_ADDR_CFG_A 6'h02
`define WPC_ADDR_CFG_B 6'h03
`define WPC_FRAME_WR_BIT 15
`define WPC_FRAME_ADDR_MSB 14
`define WPC_FRAME_ADDR_LSB 9
`define WPC_FRAME_PARITY_BIT 8
`define WPC_CFG_A_RESET 8'h00
`define WPC_CFG_B_RESET 8'h00
`define WPC_B_PIN5_MSB 7
`define WPC_B_PIN5_LSB 6
`define WPC_B_CAN_FAILSAFE_BIT 5
`define WPC_B_CAN_TIMEOUT_BIT 4
`define WPC_B_RESERVED_BIT 3
`define WPC_B_LIN_LOWSUP_BIT 2
`define WPC_B_LIN_RATE_MSB 1
`define WPC_B_LIN_RATE_LSB 0
`define WPC_CLK_PERIOD_NS 10
`define WPC_CAN_TO_SHORT_US 120
`define WPC_CAN_TO_LONG_US 2800
`define WPC_CAN_TO_SHORT_CYC (`WPC_CAN_TO_SHORT_US * 1000 / `WPC_CLK_PERIOD_NS)
`define WPC_CAN_TO_LONG_CYC (`WPC_CAN_TO_LONG_US * 1000 / `WPC_CLK_PERIOD_NS)
`endif

// >>> design/wpc_pkg.sv
// types for the wake pin and transceiver configuration registers
package wpc_pkg;
   typedef enum logic [1:0] {
      WPC_WAKE_NONE = 2'h0,
      WPC_WAKE_RISE_HIGH = 2'h1,
      WPC_WAKE_FALL_LOW = 2'h2,
      WPC_WAKE_ANY_EDGE = 2'h3
   } wpc_wake_sel_type;
   typedef enum logic [1:0] {
      WPC_LIN_RATE_20K,
      WPC_LIN_RATE_10K,
      WPC_LIN_RATE_FAST
   } wpc_lin_rate_type;
endpackage

// >>> design/wpc_wake_decode.sv
// decodes one pin wake selection into enable and polarity controls
`timescale 1ns/1ps
module wpc_wake_decode (
   input wire logic clk, // system clock
   input wire logic reset, // power-on reset, async, active high
   input wire logic [1:0] sel, // wake selection code
   output logic rise_en_r, // wake on rising edge or high level
   output logic fall_en_r // wake on falling edge or low level
);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rise_en_r <= 1'b0;
         fall_en_r <= 1'b0;
      end else begin
         unique case (wpc_pkg::wpc_wake_sel_type'(sel))
            wpc_pkg::WPC_WAKE_NONE: begin // [R3]
               rise_en_r <= 1'b0;
               fall_en_r <= 1'b0;
            end
            wpc_pkg::WPC_WAKE_RISE_HIGH: begin // [R3]
               rise_en_r <= 1'b1;
               fall_en_r <= 1'b0;
            end
            wpc_pkg::WPC_WAKE_FALL_LOW: begin // [R4]
               rise_en_r <= 1'b0;
               fall_en_r <= 1'b1;
            end
            wpc_pkg::WPC_WAKE_ANY_EDGE: begin // [R3]
               rise_en_r <= 1'b1;
               fall_en_r <= 1'b1;
            end
         endcase
      end
   end
endmodule

// >>> design/wpc_regs.sv
// wake pin and transceiver configuration registers with frame response
`include "wpc_defs.svh"
`timescale 1ns/1ps
module wpc_regs (
   input wire logic clk, // system clock
   input wire logic reset, // power-on reset of main logic
   input wire logic frame_valid, // one-cycle pulse: frame received
   input wire logic [15:0] frame_in, // received host frame
   input wire logic [7:0] global_flags, // serial,wake,can,lin,io,pre,core,other
   input wire logic lin_supply_low, // supply below 7.0 V
   output logic resp_valid_r, // one-cycle pulse: response ready
   output logic [15:0] resp_data_r, // response frame
   output logic [7:0] cfg_a_r, // first wake register content
   output logic [7:0] cfg_b_r, // second wake register content
   output logic [4:0] wake_rise_en_r, // pins 0,2,3,4,5 rising/high wake
   output logic [4:0] wake_fall_en_r, // pins 0,2,3,4,5 falling/low wake
   output logic can_failsafe_sleep_r, // can sleeps instead of rx-only
   output logic [18:0] can_wake_timeout_cyc_r, // can wake timeout cycles
   output logic [1:0] lin_edge_rate_sel_r, // decoded lin slew setting
   output logic lin_force_recessive_r // lin driver held recessive
);
   logic wr;
   logic [5:0] addr;
   logic [1:0] pin_sel [5];
   logic [9:0] dec_q;

   assign wr = frame_in[`WPC_FRAME_WR_BIT];
   assign addr = frame_in[`WPC_FRAME_ADDR_MSB:`WPC_FRAME_ADDR_LSB];

   ////////////////////////////////////////////////////////////////////////
   // register writes; power-on reset is the only clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_a_r <= `WPC_CFG_A_RESET; // [R5]
      end else if (frame_valid && wr && addr == `WPC_ADDR_CFG_A) begin
         cfg_a_r <= frame_in[7:0]; // [R1] [R2]
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_b_r <= `WPC_CFG_B_RESET; // [R5]
      end else if (frame_valid && wr && addr == `WPC_ADDR_CFG_B) begin
         // reserved bit is kept zero whatever the host sends
         cfg_b_r <= frame_in[7:0] & 8'hF7; // [R7]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // response: flags high, content after any write in the same frame
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         resp_valid_r <= 1'b0;
         resp_data_r <= 16'h0000;
      end else begin
         resp_valid_r <= 1'b0;
         if (frame_valid &&
             (addr == `WPC_ADDR_CFG_A || addr == `WPC_ADDR_CFG_B)) begin
            resp_valid_r <= 1'b1;
            resp_data_r[15:8] <= global_flags; // [R6]
            if (addr == `WPC_ADDR_CFG_A) begin
               resp_data_r[7:0] <= wr ? frame_in[7:0] : cfg_a_r; // [R6]
            end else begin
               resp_data_r[7:0] <= wr ? (frame_in[7:0] & 8'hF7)
                                      : cfg_b_r; // [R6] [R7]
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per pin wake decoding
   assign pin_sel[0] = cfg_a_r[7:6]; // [R2]
   assign pin_sel[1] = cfg_a_r[5:4];
   assign pin_sel[2] = cfg_a_r[3:2];
   assign pin_sel[3] = cfg_a_r[1:0];
   assign pin_sel[4] = cfg_b_r[`WPC_B_PIN5_MSB:`WPC_B_PIN5_LSB]; // [R7]

   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_pin
         wpc_wake_decode u_dec (
            .clk(clk),
            .reset(reset),
            .sel(pin_sel[g]),
            .rise_en_r(dec_q[2*g]),
            .fall_en_r(dec_q[2*g+1])
         );
      end
   endgenerate

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wake_rise_en_r <= 5'h00;
         wake_fall_en_r <= 5'h00;
      end else begin
         for (int i = 0; i < 5; i++) begin
            wake_rise_en_r[i] <= dec_q[2*i];
            wake_fall_en_r[i] <= dec_q[2*i+1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transceiver controls
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         can_failsafe_sleep_r <= 1'b0;
         can_wake_timeout_cyc_r <= 19'(`WPC_CAN_TO_SHORT_CYC);
      end else begin
         can_failsafe_sleep_r <= cfg_b_r[`WPC_B_CAN_FAILSAFE_BIT]; // [R7]
         can_wake_timeout_cyc_r <= cfg_b_r[`WPC_B_CAN_TIMEOUT_BIT]
            ? 19'(`WPC_CAN_TO_LONG_CYC)
            : 19'(`WPC_CAN_TO_SHORT_CYC); // [R8]
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lin_edge_rate_sel_r <= 2'h0;
      end else if (cfg_b_r[`WPC_B_LIN_RATE_MSB]) begin
         lin_edge_rate_sel_r <= wpc_pkg::WPC_LIN_RATE_FAST; // [R9]
      end else if (cfg_b_r[`WPC_B_LIN_RATE_LSB]) begin
         lin_edge_rate_sel_r <= wpc_pkg::WPC_LIN_RATE_10K; // [R9]
      end else begin
         lin_edge_rate_sel_r <= wpc_pkg::WPC_LIN_RATE_20K; // [R9]
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lin_force_recessive_r <= 1'b0;
      end else begin
         lin_force_recessive_r <= lin_supply_low &&
            !cfg_b_r[`WPC_B_LIN_LOWSUP_BIT]; // [R10]
      end
   end
endmodule

// >>> tb/wpc_regs_properties.sv
// port assertions for the wake configuration registers
`timescale 1ns/1ps
module wpc_regs_props (
   input wire logic clk, // clock
   input wire logic reset, // reset
   input wire logic frame_valid, // in
   input wire logic [15:0] frame_in, // in
   input wire logic [7:0] global_flags, // in
   input wire logic lin_supply_low, // in
   input wire logic resp_valid_r, // out
   input wire logic [15:0] resp_data_r, // out
   input wire logic [7:0] cfg_a_r, // out
   input wire logic [7:0] cfg_b_r, // out
   input wire logic [4:0] wake_rise_en_r, // out
   input wire logic [4:0] wake_fall_en_r, // out
   input wire logic [18:0] can_wake_timeout_cyc_r, // out
   input wire logic lin_force_recessive_r // out
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   resp_frame_a: assert property (frame_valid && frame_in[14:10] == 5'h01
      |=> resp_valid_r && resp_data_r[15:8] == $past(global_flags))
      else $error("bad response");
   write_a_a: assert property (frame_valid && frame_in[15:9] == 7'h42
      |=> cfg_a_r == $past(frame_in[7:0])) else $error("bad write");
   cfg_hold_a: assert property (!frame_valid
      |=> $stable(cfg_a_r) && $stable(cfg_b_r)) else $error("cfg moved");
   rise_dec_a: assert property (wake_rise_en_r[0] == $past(cfg_a_r[6], 2))
      else $error("bad rise");
   fall_dec_a: assert property (wake_fall_en_r[0] == $past(cfg_a_r[7], 2))
      else $error("bad fall");
   rsvd_bit_a: assert property (cfg_b_r[3] == 1'b0) else $error("rsvd set");
   can_timeout_a: assert property (can_wake_timeout_cyc_r ==
      ($past(cfg_b_r[4]) ? 19'h445C0 : 19'h02EE0)) else $error("bad timeout");
   lin_recess_a: assert property (!$past(reset) && $stable(cfg_b_r)
      && $stable(lin_supply_low) |->
      lin_force_recessive_r == (lin_supply_low && !cfg_b_r[2]))
      else $error("bad recessive");
endmodule
bind wpc_regs wpc_regs_props props_u (.clk(clk), .reset(reset),
   .frame_valid(frame_valid), .frame_in(frame_in),
   .global_flags(global_flags), .lin_supply_low(lin_supply_low),
   .resp_valid_r(resp_valid_r), .resp_data_r(resp_data_r),
   .cfg_a_r(cfg_a_r), .cfg_b_r(cfg_b_r), .wake_rise_en_r(wake_rise_en_r),
   .wake_fall_en_r(wake_fall_en_r),
   .can_wake_timeout_cyc_r(can_wake_timeout_cyc_r),
   .lin_force_recessive_r(lin_force_recessive_r));

// >>> tb/wpc_host_model.sv
// host model issuing register frames
`timescale 1ns/1ps
module wpc_host_model (
   input wire logic clk, // clock
   output logic frame_valid, // strobe
   output logic [15:0] frame_in // frame
);
   initial begin
      frame_valid = 1'b0;
      frame_in = 16'hFFFF;
   end
   // word inverted after the strobe so stale data never looks valid
   task automatic send(input logic [15:0] f);
      @(negedge clk);
      frame_valid = 1'b1;
      frame_in = f;
      @(negedge clk);
      frame_valid = 1'b0;
      frame_in = ~f;
   endtask
endmodule

// >>> tb/wpc_regs_test.sv
// self-checking bench for the wake configuration registers
`timescale 1ns/1ps
module wpc_regs_test;
   logic clk, reset, lin_supply_low, resp_valid_r, can_failsafe_sleep_r;
   logic frame_valid, lin_force_recessive_r;
   logic [15:0] frame_in, resp_data_r;
   logic [7:0] global_flags, cfg_a_r, cfg_b_r;
   logic [4:0] wake_rise_en_r, wake_fall_en_r;
   logic [18:0] can_wake_timeout_cyc_r;
   logic [1:0] lin_edge_rate_sel_r;
   int num_errors = 0, check_count = 0, cyc = 0;
   wpc_host_model host_u (.clk(clk), .frame_valid(frame_valid),
      .frame_in(frame_in));
   wpc_regs dut_u (.clk(clk), .reset(reset), .frame_valid(frame_valid),
      .frame_in(frame_in), .global_flags(global_flags),
      .lin_supply_low(lin_supply_low), .resp_valid_r(resp_valid_r),
      .resp_data_r(resp_data_r), .cfg_a_r(cfg_a_r), .cfg_b_r(cfg_b_r),
      .wake_rise_en_r(wake_rise_en_r), .wake_fall_en_r(wake_fall_en_r),
      .can_failsafe_sleep_r(can_failsafe_sleep_r),
      .can_wake_timeout_cyc_r(can_wake_timeout_cyc_r),
      .lin_edge_rate_sel_r(lin_edge_rate_sel_r),
      .lin_force_recessive_r(lin_force_recessive_r));
   task automatic chk(string n, logic [18:0] e, logic [18:0] s);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic xfer(logic [15:0] f, logic [7:0] d);
      host_u.send(f);
      chk("resp_valid", 19'h00001, resp_valid_r);
      chk("resp_data", {global_flags, d}, resp_data_r);
   endtask
   task automatic test_codes;
      for (logic [2:0] c = 0; c < 4; c++) begin
         global_flags = 8'h5A ^ {6'h00, c[1:0]};
         xfer(16'h8400 | {8'h00, {4{c[1:0]}}}, {4{c[1:0]}});
         xfer(16'h0400, {4{c[1:0]}});
         repeat (2) @(negedge clk);
         chk("rise", {1'b0, {4{c[0]}}}, wake_rise_en_r);
         chk("fall", {1'b0, {4{c[1]}}}, wake_fall_en_r);
      end
      $display("codes done");
   endtask
   task automatic test_regb;
      lin_supply_low = 1'b1;
      xfer(16'h86FF, 8'hF7);
      @(negedge clk);
      chk("timeout", 19'h445C0, can_wake_timeout_cyc_r);
      chk("rate", 19'h00002, lin_edge_rate_sel_r);
      chk("recessive", 19'h00000, lin_force_recessive_r);
      chk("failsafe", 19'h00001, can_failsafe_sleep_r);
      @(negedge clk);
      chk("pin5_rise", 19'h00001, wake_rise_en_r[4]);
      chk("pin5_fall", 19'h00001, wake_fall_en_r[4]);
      xfer(16'h8601, 8'h01);
      @(negedge clk);
      chk("timeout", 19'h02EE0, can_wake_timeout_cyc_r);
      chk("rate", 19'h00001, lin_edge_rate_sel_r);
      chk("recessive", 19'h00001, lin_force_recessive_r);
      chk("failsafe", 19'h00000, can_failsafe_sleep_r);
      $display("regb done");
   endtask
   task automatic test_refuse;
      xfer(16'h8555, 8'h55);
      host_u.send(16'h88AA);
      chk("no_resp", 19'h00000, resp_valid_r);
      chk("cfg_a", 19'h00055, cfg_a_r);
      $display("refuse done");
   endtask
   task automatic test_reset;
      @(negedge clk);
      reset = 1'b1;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      chk("cfg_a", 19'h00000, cfg_a_r);
      chk("cfg_b", 19'h00000, cfg_b_r);
      chk("timeout", 19'h02EE0, can_wake_timeout_cyc_r);
      repeat (3) @(negedge clk);
      chk("rise", 19'h00000, wake_rise_en_r);
      xfer(16'h0600, 8'h00);
      $display("reset done");
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         stop_test;
      end
   end
   initial begin
      reset = 1'b1;
      global_flags = 8'h00;
      lin_supply_low = 1'b0;
      repeat (10) @(negedge clk);
      reset = 1'b0;
      test_codes;
      test_regb;
      test_refuse;
      test_reset;
      stop_test;
   end
endmodule
